// *** udr_defs.svh ***
// Constants for the USB descriptor responder: field values, offsets, byte counts.
// Assumes inclusion by bare name from the package and the responder module.
`ifndef UDR_DEFS_SVH
`define UDR_DEFS_SVH
// Common header layout.
`define UDR_OFF_LEN      4'h0
`define UDR_OFF_TYPE     4'h1
// Interrupt endpoint descriptor.
`define UDR_EP_LEN       8'h07
`define UDR_EP_TYPE      8'h05
`define UDR_EP_ADDR      8'h83
`define UDR_EP_ATTR      8'h03
`define UDR_EP_MPS       16'h0010
`define UDR_EP_INT_HS    8'h04
`define UDR_EP_INT_FS    8'h01
`define UDR_EP_OFF_ADDR  4'h2
`define UDR_EP_OFF_MPS   4'h4
`define UDR_EP_OFF_INT   4'h6
`define UDR_EP_BYTES     4'h7
// Other-speed configuration descriptor.
`define UDR_OSC_LEN      8'h09
`define UDR_OSC_TYPE     8'h07
`define UDR_OSC_TOTAL    16'h0027
`define UDR_OSC_NUMIF    8'h01
`define UDR_OSC_CFGVAL   8'h01
`define UDR_OSC_ICFG     8'h00
`define UDR_OSC_ATTR     8'he0
`define UDR_PWR_SELF     8'h01
`define UDR_PWR_BUS      8'hfa
`define UDR_OSC_OFF_PWR  4'h8
`define UDR_OSC_BYTES    4'h9
// Device qualifier descriptor.
`define UDR_QUAL_LEN     8'h0a
`define UDR_QUAL_TYPE    8'h06
`define UDR_QUAL_BCD     16'h0210
`define UDR_QUAL_CLASS   8'hff
`define UDR_QUAL_SUB     8'h00
`define UDR_QUAL_PROTO   8'hff
`define UDR_QUAL_MPS0    8'h40
`define UDR_QUAL_NUMCFG  8'h01
`define UDR_QUAL_RSVD    8'h00
`define UDR_QUAL_OFF_RSV 4'h9
`define UDR_QUAL_BYTES   4'ha
// Language-identifier string descriptor.
`define UDR_LANG_LEN     8'h04
`define UDR_LANG_TYPE    8'h03
`define UDR_LANG_OFF     4'h2
`define UDR_LANG_BYTES   4'h4
`endif

// *** udr_pkg.sv ***
// Types shared by the USB descriptor responder modules.
// Assumes udr_defs.svh is on the include path.
`include "udr_defs.svh"
package udr_pkg;
  typedef enum logic [3:0] {
    UDR_K_EP   = 4'b0001,
    UDR_K_OSC  = 4'b0010,
    UDR_K_QUAL = 4'b0100,
    UDR_K_LANG = 4'b1000
  } udr_kind_t;

  typedef enum logic [2:0] {
    UDR_ST_IDLE = 3'b001,
    UDR_ST_SEND = 3'b010,
    UDR_ST_END  = 3'b100
  } udr_state_t;

  typedef struct packed {
    logic [7:0]  length;
    logic [15:0] total;
    logic [7:0]  num_if;
    logic [7:0]  cfg_val;
    logic [7:0]  icfg;
    logic [7:0]  attr;
    logic [7:0]  max_power;
  } udr_cfg_set_t;

  typedef struct packed {
    logic [15:0] bcd;
    logic [7:0]  dclass;
    logic [7:0]  subclass;
    logic [7:0]  protocol;
    logic [7:0]  mps0;
    logic [7:0]  num_cfg;
  } udr_dev_set_t;

  typedef struct packed {
    logic         valid;
    logic         strings_present;
    logic [7:0]   int_hs;
    logic [7:0]   int_fs;
    udr_cfg_set_t cfg_hs;
    udr_cfg_set_t cfg_fs;
    udr_dev_set_t dev_hs;
    udr_dev_set_t dev_fs;
    logic [15:0]  langid;
  } udr_nvm_t;

  typedef struct packed {
    udr_kind_t   kind;
    logic [15:0] langid;
    logic [15:0] max_len;
  } udr_req_t;

  // Full byte count of each descriptor kind.
  function automatic logic [3:0] udr_desc_len(input udr_kind_t kind);
    unique case (kind)
      UDR_K_EP:   udr_desc_len = `UDR_EP_BYTES;
      UDR_K_OSC:  udr_desc_len = `UDR_OSC_BYTES;
      UDR_K_QUAL: udr_desc_len = `UDR_QUAL_BYTES;
      UDR_K_LANG: udr_desc_len = `UDR_LANG_BYTES;
      default:    udr_desc_len = 4'h0;
    endcase
  endfunction
endpackage

// *** udr_desc_rom.sv ***
// Descriptor byte source: builds the image of one descriptor and picks a byte.
// Assumes the nonvolatile image is stable while a descriptor is being sent.
`timescale 1ns/1ps
module udr_desc_rom
  import udr_pkg::*;
(
  input  wire udr_kind_t  kind,         // Descriptor being sent.
  input  wire logic       high_speed,   // Speed captured for this transfer.
  input  wire logic       self_powered, // Power mode captured for this transfer.
  input  wire udr_nvm_t   nvm,          // Contents loaded from storage.
  input  wire logic [3:0] pos,          // Byte offset to fetch.
  output logic [7:0]      byte_out      // Byte at that offset.
);
  logic [79:0]  img;
  udr_cfg_set_t cfg;
  udr_dev_set_t dev;
  logic [7:0]   interval;

  // Pick the opposite-speed sets and the same-speed interval, or the defaults when storage is absent.
  always_comb begin
    cfg = '{`UDR_OSC_LEN, `UDR_OSC_TOTAL, `UDR_OSC_NUMIF, `UDR_OSC_CFGVAL, `UDR_OSC_ICFG,
            `UDR_OSC_ATTR, (self_powered ? `UDR_PWR_SELF : `UDR_PWR_BUS)};
    dev = '{`UDR_QUAL_BCD, `UDR_QUAL_CLASS, `UDR_QUAL_SUB, `UDR_QUAL_PROTO,
            `UDR_QUAL_MPS0, `UDR_QUAL_NUMCFG};
    interval = high_speed ? `UDR_EP_INT_HS : `UDR_EP_INT_FS;
    if (nvm.valid) begin
      cfg = high_speed ? nvm.cfg_fs : nvm.cfg_hs;
      dev = high_speed ? nvm.dev_fs : nvm.dev_hs;
      interval = high_speed ? nvm.int_hs : nvm.int_fs;
    end
  end

  // Lay out the image with offset 0 in the low byte, words low byte first.
  always_comb begin
    img = '0;
    unique case (kind)
      UDR_K_EP: begin
        img[55:0] = {interval, `UDR_EP_MPS, `UDR_EP_ATTR, `UDR_EP_ADDR,
                     `UDR_EP_TYPE, `UDR_EP_LEN};
      end
      UDR_K_OSC: begin
        img[71:0] = {cfg.max_power, cfg.attr, cfg.icfg, cfg.cfg_val, cfg.num_if,
                     cfg.total, `UDR_OSC_TYPE, cfg.length};
      end
      UDR_K_QUAL: begin
        img[79:0] = {`UDR_QUAL_RSVD, dev.num_cfg, dev.mps0, dev.protocol, dev.subclass,
                     dev.dclass, dev.bcd, `UDR_QUAL_TYPE, `UDR_QUAL_LEN};
      end
      UDR_K_LANG: begin
        img[31:0] = {nvm.langid, `UDR_LANG_TYPE, `UDR_LANG_LEN};
      end
      default: begin
        img = '0;
      end
    endcase
  end

  // Offsets past the image read as zero.
  always_comb begin
    byte_out = (pos < 4'ha) ? img[{pos, 3'b000} +: 8] : 8'h00;
  end
endmodule

// *** udr_responder.sv ***
// USB descriptor responder: answers endpoint-0 reads of four standard descriptors.
// Assumes the control endpoint decodes the setup stage and drains the byte stream.
`timescale 1ns/1ps
`include "udr_defs.svh"
module udr_responder
  import udr_pkg::*;
#(
  parameter int LEN_W = 16  // Width of the host's requested length.
) (
  input  wire logic       mclk,         // Controller clock, 125 MHz.
  input  wire logic       reset_n,      // Asynchronous reset, active low.
  input  wire udr_req_t   req,          // Descriptor read request.
  input  wire logic       req_valid,    // Request offered.
  output logic            req_ready,    // Responder idle and taking requests.
  input  wire logic       high_speed,   // Link is at high speed.
  input  wire logic       self_powered, // Device is self-powered.
  input  wire udr_nvm_t   nvm,          // Contents loaded from storage.
  output logic [7:0]      tx_data,      // Data-stage byte.
  output logic            tx_valid,     // Data-stage byte offered.
  output logic            tx_last,      // Offered byte is the last one.
  input  wire logic       tx_ready,     // Endpoint takes the byte.
  output logic            stall,        // Pulse: stall the data stage.
  output logic            done          // Pulse: data stage complete.
);
  udr_state_t  state;
  udr_state_t  next_state;
  udr_kind_t   cur_kind;
  logic        cur_hs;
  logic        cur_self;
  logic        end_stall;
  logic [3:0]  count;
  logic [3:0]  pos;
  logic [3:0]  tx_pos;
  logic [3:0]  req_cnt;
  logic [3:0]  full_len;
  logic        req_stall;
  logic        accept;
  logic [7:0]  rom_byte;

  // The length field must cover the longest descriptor; refuse a narrower one at elaboration.
  if (LEN_W < 4) begin : g_len_check
    $error("udr_responder: LEN_W must be at least 4");
  end

  udr_desc_rom u_rom (
    .kind         (cur_kind),
    .high_speed   (cur_hs),
    .self_powered (cur_self),
    .nvm          (nvm),
    .pos          (pos),
    .byte_out     (rom_byte)
  );

  // Request decode; the requested language identifier plays no part.
  always_comb begin
    accept    = req_valid && req_ready;
    full_len  = udr_desc_len(req.kind);
    req_cnt   = (req.max_len < LEN_W'(full_len)) ? req.max_len[3:0] : full_len;
    req_stall = (req.kind == UDR_K_LANG) && !(nvm.valid && nvm.strings_present);
  end

  // Next-state decision for the transfer sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      UDR_ST_IDLE: begin
        if (accept) begin
          next_state = (req_stall || (req_cnt == 4'h0)) ? UDR_ST_END : UDR_ST_SEND;
        end
      end
      UDR_ST_SEND: begin
        if (tx_valid && tx_ready && tx_last) begin
          next_state = UDR_ST_END;
        end
      end
      UDR_ST_END: begin
        next_state = UDR_ST_IDLE;
      end
      default: begin
        next_state = UDR_ST_IDLE;
      end
    endcase
  end

  // Sequencer state and the ready flag that follows it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= UDR_ST_IDLE;
      req_ready <= 1'b1;
    end else begin
      state     <= next_state;
      req_ready <= (next_state == UDR_ST_IDLE);
    end
  end

  // Capture what the transfer needs at the moment the request is taken.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_kind  <= UDR_K_EP;
      cur_hs    <= 1'b0;
      cur_self  <= 1'b0;
      end_stall <= 1'b0;
      count     <= 4'h0;
    end else if (accept) begin
      cur_kind  <= req.kind;
      cur_hs    <= high_speed;
      cur_self  <= self_powered;
      end_stall <= req_stall;
      count     <= req_cnt;
    end
  end

  // Byte stream: load the next offset whenever the output register is free.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pos      <= 4'h0;
      tx_pos   <= 4'h0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
    end else if (state == UDR_ST_IDLE) begin
      pos      <= 4'h0;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end else if (state == UDR_ST_SEND) begin
      if (tx_valid && tx_ready && tx_last) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end else if ((!tx_valid || tx_ready) && (pos < count)) begin
        tx_valid <= 1'b1;
        tx_data  <= rom_byte;
        tx_pos   <= pos;
        tx_last  <= (pos == count - 4'h1);
        pos      <= pos + 4'h1;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // Closing pulse: stall for a missing string, done otherwise.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stall <= 1'b0;
      done  <= 1'b0;
    end else begin
      stall <= (state == UDR_ST_END) && end_stall;
      done  <= (state == UDR_ST_END) && !end_stall;
    end
  end

  // Checks on the bytes and the closing pulses the responder drives.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Word-sized constants, so that each byte of a word can be checked on its own.
  localparam logic [15:0] EP_MPS    = `UDR_EP_MPS;
  localparam logic [15:0] OSC_TOTAL = `UDR_OSC_TOTAL;
  localparam logic [15:0] QUAL_BCD  = `UDR_QUAL_BCD;

  logic [7:0] exp_int;
  udr_cfg_set_t exp_cfg;
  udr_dev_set_t exp_dev;
  always_comb begin
    exp_int = nvm.valid ? (cur_hs ? nvm.int_hs : nvm.int_fs)
                        : (cur_hs ? `UDR_EP_INT_HS : `UDR_EP_INT_FS);
    exp_cfg = cur_hs ? nvm.cfg_fs : nvm.cfg_hs;
    exp_dev = cur_hs ? nvm.dev_fs : nvm.dev_hs;
  end

  a_ep_fixed_bytes: assert property ((tx_valid && cur_kind == UDR_K_EP) |->
      ((tx_pos == `UDR_OFF_LEN) -> tx_data == `UDR_EP_LEN) &&
      ((tx_pos == `UDR_EP_OFF_ADDR) -> tx_data == `UDR_EP_ADDR) &&
      ((tx_pos == 4'h3) -> tx_data == `UDR_EP_ATTR))
    else $error("interrupt endpoint fixed byte wrong");

  a_ep_max_packet: assert property ((tx_valid && cur_kind == UDR_K_EP &&
      tx_pos == `UDR_EP_OFF_MPS && tx_ready && !tx_last) |=>
      (tx_data == EP_MPS[15:8]))
    else $error("interrupt endpoint packet size high byte wrong");

  a_ep_mps_low: assert property ((tx_valid && cur_kind == UDR_K_EP &&
      tx_pos == `UDR_EP_OFF_MPS) |-> tx_data == EP_MPS[7:0])
    else $error("interrupt endpoint packet size low byte wrong");

  a_ep_poll_interval: assert property ((tx_valid && cur_kind == UDR_K_EP &&
      tx_pos == `UDR_EP_OFF_INT) |-> tx_data == exp_int)
    else $error("interrupt endpoint interval wrong for speed");

  a_osc_type_fixed: assert property ((tx_valid && cur_kind == UDR_K_OSC &&
      tx_pos == `UDR_OFF_TYPE) |-> tx_data == `UDR_OSC_TYPE)
    else $error("other-speed type not 07h");

  a_osc_other_speed: assert property ((tx_valid && cur_kind == UDR_K_OSC &&
      nvm.valid && tx_pos == `UDR_OFF_LEN) |-> tx_data == exp_cfg.length)
    else $error("other-speed length not from opposite set");

  a_osc_total_word: assert property ((tx_valid && cur_kind == UDR_K_OSC) |->
      ((tx_pos == 4'h2) -> tx_data == (nvm.valid ? exp_cfg.total[7:0] : OSC_TOTAL[7:0])) &&
      ((tx_pos == 4'h3) -> tx_data == (nvm.valid ? exp_cfg.total[15:8] : OSC_TOTAL[15:8])))
    else $error("other-speed total length wrong");

  a_osc_power_dflt: assert property ((tx_valid && cur_kind == UDR_K_OSC &&
      !nvm.valid && tx_pos == `UDR_OSC_OFF_PWR) |->
      tx_data == (cur_self ? `UDR_PWR_SELF : `UDR_PWR_BUS))
    else $error("other-speed default power wrong");

  a_osc_power_stored: assert property ((tx_valid && cur_kind == UDR_K_OSC &&
      nvm.valid && tx_pos == `UDR_OSC_OFF_PWR) |-> tx_data == exp_cfg.max_power)
    else $error("other-speed stored power not from opposite set");

  a_osc_attr_dflt: assert property ((tx_valid && cur_kind == UDR_K_OSC &&
      !nvm.valid && tx_pos == 4'h7) |-> tx_data == `UDR_OSC_ATTR)
    else $error("other-speed default attributes wrong");

  a_qual_fixed_bytes: assert property ((tx_valid && cur_kind == UDR_K_QUAL) |->
      ((tx_pos == `UDR_OFF_LEN) -> tx_data == `UDR_QUAL_LEN) &&
      ((tx_pos == `UDR_OFF_TYPE) -> tx_data == `UDR_QUAL_TYPE) &&
      ((tx_pos == `UDR_QUAL_OFF_RSV) -> tx_data == `UDR_QUAL_RSVD))
    else $error("qualifier fixed byte wrong");

  a_qual_opposite_set: assert property ((tx_valid && cur_kind == UDR_K_QUAL &&
      tx_pos == 4'h7) |->
      tx_data == (nvm.valid ? exp_dev.mps0 : `UDR_QUAL_MPS0))
    else $error("qualifier packet size not from opposite set");

  a_qual_bcd_word: assert property ((tx_valid && cur_kind == UDR_K_QUAL) |->
      ((tx_pos == 4'h2) -> tx_data == (nvm.valid ? exp_dev.bcd[7:0] : QUAL_BCD[7:0])) &&
      ((tx_pos == 4'h3) -> tx_data == (nvm.valid ? exp_dev.bcd[15:8] : QUAL_BCD[15:8])))
    else $error("qualifier release number wrong");

  a_lang_header: assert property ((tx_valid && cur_kind == UDR_K_LANG &&
      tx_pos == `UDR_OFF_TYPE) |-> tx_data == `UDR_LANG_TYPE)
    else $error("language string type not 03h");

  a_lang_length: assert property ((tx_valid && cur_kind == UDR_K_LANG &&
      tx_pos == `UDR_OFF_LEN) |-> tx_data == `UDR_LANG_LEN)
    else $error("language string length not 04h");

  a_lang_stall: assert property ((accept && req_stall) |->
      ##2 (stall && !done) ##1 !stall)
    else $error("missing language string not stalled");

  a_lang_code: assert property ((tx_valid && cur_kind == UDR_K_LANG &&
      tx_pos == `UDR_LANG_OFF) |-> tx_data == nvm.langid[7:0])
    else $error("language code low byte wrong");

  a_lang_code_high: assert property ((tx_valid && cur_kind == UDR_K_LANG &&
      tx_pos == 4'h3) |-> tx_data == nvm.langid[15:8])
    else $error("language code high byte wrong");

  a_lang_no_data: assert property ((accept && req_stall) |->
      !tx_valid [*4])
    else $error("data sent for a stalled language read");

  a_done_after_last: assert property ((tx_valid && tx_ready && tx_last) |->
      ##2 (done && !stall))
    else $error("finished data stage not closed with done");

  a_byte_order: assert property ((tx_valid && tx_ready && !tx_last) |=>
      (tx_valid && tx_pos == $past(tx_pos) + 4'h1))
    else $error("bytes not in ascending order");

  a_stream_steady: assert property ((tx_valid && !tx_ready) |=>
      (tx_valid && $stable(tx_data) && $stable(tx_pos)))
    else $error("offered byte changed before it was taken");

  a_within_length: assert property (tx_valid |->
      tx_pos < udr_desc_len(cur_kind))
    else $error("byte offered past the end of the descriptor");

  a_first_byte: assert property ((accept && !req_stall && req_cnt != 4'h0) |->
      ##2 (tx_valid && tx_pos == 4'h0))
    else $error("first byte not at offset zero two cycles after request");

  c_ep_whole: cover property (tx_valid && tx_ready && tx_last && cur_kind == UDR_K_EP &&
      tx_pos == `UDR_EP_OFF_INT);
  c_lang_stall: cover property (stall);
  c_lang_sent: cover property (tx_valid && tx_ready && tx_last && cur_kind == UDR_K_LANG);
  c_qual_whole: cover property (tx_valid && tx_ready && tx_last && tx_pos == 4'h9);
  c_osc_backpressure: cover property (tx_valid && !tx_ready && cur_kind == UDR_K_OSC);
endmodule

// *** udr_host_model.sv ***
// Host-side model for the descriptor responder: offers one request, drains the bytes.
// Assumes a single responder on mclk; the testbench calls read and inspects got.
`timescale 1ns/1ps
module udr_host_model
  import udr_pkg::*;
(
  input  wire logic       mclk,      // Controller clock.
  output udr_req_t        req,       // Descriptor read request.
  output logic            req_valid, // Request offered.
  input  wire logic       req_ready, // Responder takes requests.
  input  wire logic [7:0] tx_data,   // Data-stage byte.
  input  wire logic       tx_valid,  // Byte offered.
  input  wire logic       tx_last,   // Offered byte is the last one.
  output logic            tx_ready,  // Host takes the byte.
  input  wire logic       stall,     // Stall pulse.
  input  wire logic       done       // Completion pulse.
);
  logic [8:0] got[$];    // Bytes taken, with the last flag in bit 8.
  logic       stalled;   // The data stage ended in a stall.
  logic       timed_out; // The responder never finished.
  int         seed;      // Seed for the stalling pattern.

  // Idle host: nothing offered, ready to take bytes.
  initial begin
    seed      = 32'h873a83e2;
    req       = '0;
    req_valid = 1'b0;
    tx_ready  = 1'b1;
    stalled   = 1'b0;
    timed_out = 1'b0;
  end

  // One control read; a slow host drops tx_ready at random to stall the stream.
  task automatic read(input udr_req_t r, input bit slow);
    int n;
    got       = {};
    stalled   = 1'b0;
    timed_out = 1'b0;
    n         = 0;
    req       <= r;
    req_valid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!req_ready && n < 50);
    req_valid <= 1'b0;
    req       <= udr_req_t'(~r); // A released request shows no stale value.
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (tx_valid && tx_ready) begin
        got.push_back({tx_last, tx_data});
      end
      if (stall) begin
        stalled = 1'b1;
      end
      tx_ready <= slow ? 1'($random(seed)) : 1'b1;
    end while (!(stall || done) && n < 200);
    timed_out = (n >= 200);
    tx_ready <= 1'b1;
  endtask
endmodule

// *** udr_responder_test.sv ***
// Self-checking testbench for the descriptor responder with a host model.
// Assumes udr_pkg and the design modules are compiled first.
`timescale 1ns/1ps
module udr_responder_test
  import udr_pkg::*;
;
  typedef logic [8:0] udr_beat_q_t[$];

  logic        mclk;
  logic        reset_n;
  udr_req_t    req;
  logic        req_valid;
  logic        req_ready;
  logic        high_speed;
  logic        self_powered;
  udr_nvm_t    nvm;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        tx_ready;
  logic        stall;
  logic        done;
  int          seed;
  int          n_mismatch;
  int          total_checks;
  udr_kind_t   kinds[4] = '{UDR_K_EP, UDR_K_OSC, UDR_K_QUAL, UDR_K_LANG};

  // Clock at 125 MHz.
  always #4 mclk = ~mclk;

  udr_responder #(.LEN_W(16)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .high_speed(high_speed), .self_powered(self_powered),
    .nvm(nvm), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .stall(stall), .done(done)
  );

  udr_host_model i_host (
    .mclk(mclk), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .stall(stall), .done(done)
  );

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Random storage image; required fields keep their defaults, language code fixed.
  function automatic udr_nvm_t rand_nvm();
    logic [319:0] raw;
    udr_nvm_t     m;
    for (int i = 0; i < 10; i++) raw[i*32 +: 32] = $random(seed);
    m = raw[$bits(udr_nvm_t)-1:0];
    m.valid = |raw[319:318];
    m.cfg_hs.length = 8'h09;
    m.cfg_fs.length = 8'h09;
    m.cfg_hs.total = 16'h0027;
    m.cfg_fs.total = 16'h0027;
    m.cfg_hs.num_if = 8'h01;
    m.cfg_fs.num_if = 8'h01;
    m.cfg_hs.cfg_val = 8'h01;
    m.cfg_fs.cfg_val = 8'h01;
    m.dev_hs.mps0 = 8'h40;
    m.dev_fs.mps0 = 8'h40;
    m.dev_hs.num_cfg = 8'h01;
    m.dev_fs.num_cfg = 8'h01;
    m.langid = 16'h0409;
    return m;
  endfunction

  // Expected byte stream for one request, last flag in bit 8.
  function automatic udr_beat_q_t expect_beats(input udr_kind_t k, input logic [15:0] ml);
    udr_cfg_set_t c;
    udr_dev_set_t d;
    logic [7:0]   b[$];
    udr_beat_q_t  q;
    c = high_speed ? nvm.cfg_fs : nvm.cfg_hs;
    d = high_speed ? nvm.dev_fs : nvm.dev_hs;
    if (!nvm.valid) begin
      c = '{8'h09, 16'h0027, 8'h01, 8'h01, 8'h00, 8'he0, self_powered ? 8'h01 : 8'hfa};
      d = '{16'h0210, 8'hff, 8'h00, 8'hff, 8'h40, 8'h01};
    end
    case (k)
      UDR_K_EP: b = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00,
                      nvm.valid ? (high_speed ? nvm.int_hs : nvm.int_fs)
                                : (high_speed ? 8'h04 : 8'h01)};
      UDR_K_OSC: b = '{c.length, 8'h07, c.total[7:0], c.total[15:8], c.num_if,
                       c.cfg_val, c.icfg, c.attr, c.max_power};
      UDR_K_QUAL: b = '{8'h0a, 8'h06, d.bcd[7:0], d.bcd[15:8], d.dclass, d.subclass,
                        d.protocol, d.mps0, d.num_cfg, 8'h00};
      default: begin
        if (nvm.valid && nvm.strings_present) begin
          b = '{8'h04, 8'h03, nvm.langid[7:0], nvm.langid[15:8]};
        end
      end
    endcase
    foreach (b[i]) begin
      if (i < ml) begin
        q.push_back({(i == b.size() - 1) || (i == ml - 1), b[i]});
      end
    end
    return q;
  endfunction

  // One host read with a random language code, checked beat by beat.
  task automatic run_case(input udr_kind_t k, input logic [15:0] ml, input bit slow);
    udr_req_t    r;
    udr_beat_q_t exp_q;
    logic        exp_stall;
    r = '{k, 16'($random(seed)), ml};
    exp_q = expect_beats(k, ml);
    exp_stall = (k == UDR_K_LANG) && !(nvm.valid && nvm.strings_present);
    i_host.read(r, slow);
    check("finish", 32'(i_host.timed_out), 32'h0);
    check("stall", 32'(i_host.stalled), 32'(exp_stall));
    check("count", i_host.got.size(), exp_q.size());
    foreach (exp_q[i]) begin
      check("beat", i < i_host.got.size() ? 32'(i_host.got[i]) : 'x, 32'(exp_q[i]));
    end
  endtask

  // Watchdog at 20000 cycles, well beyond the expected several hundred.
  initial begin
    #(20000 * 8);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence: reset, defaults, random images, corner cases.
  initial begin
    seed = 32'h873a83e2;
    n_mismatch = 0;
    total_checks = 0;
    mclk = 1'b0;
    reset_n = 1'b0;
    high_speed = 1'b0;
    self_powered = 1'b0;
    nvm = '0;
    repeat (5) @(posedge mclk);
    check("reset_ready", 32'(req_ready), 32'h1);
    check("reset_valid", 32'({tx_valid, tx_last, stall, done}), 32'h0);
    reset_n <= 1'b1;
    @(posedge mclk);
    // Built-in defaults for every kind, speed and power mode.
    for (int s = 0; s < 4; s++) begin
      high_speed <= s[0];
      self_powered <= s[1];
      @(posedge mclk);
      foreach (kinds[j]) run_case(kinds[j], 16'h0040, s[1]);
    end
    // Random stored images, speeds, lengths and stalling.
    for (int n = 0; n < 40; n++) begin
      nvm <= rand_nvm();
      high_speed <= 1'($random(seed));
      self_powered <= 1'($random(seed));
      @(posedge mclk);
      run_case(kinds[$unsigned($random(seed)) % 4],
               (n % 5 == 0) ? 16'hffff : 16'(1 + $unsigned($random(seed)) % 12),
               1'($random(seed)));
    end
    // Valid storage without strings, then zero and one byte requests back to back.
    nvm.valid <= 1'b1;
    nvm.strings_present <= 1'b0;
    @(posedge mclk);
    run_case(UDR_K_LANG, 16'h00ff, 1'b0);
    run_case(UDR_K_EP, 16'h0000, 1'b0);
    run_case(UDR_K_EP, 16'h0001, 1'b0);
    run_case(UDR_K_QUAL, 16'h0009, 1'b1);
    report_and_stop();
  end
endmodule
